// file: rtl/mic_apb.sv
// APB slave handshake with one wait state and registered answers
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_apb
	import mic_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Register file side
	input  wire logic        mapped,
	input  wire logic [31:0] rd_data,
	output logic             wr_stb
);

	mic_apb_st_t st;
	wire         access;
	wire         first;

	assign access = psel && penable;
	assign first  = access && (st == MIC_APB_IDLE);
	// Write lands on the edge where pready is seen high
	assign wr_stb = ce && access && pwrite && mapped && (st == MIC_APB_RESP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st      <= MIC_APB_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `MIC_RST_WORD;
		end else if (ce) begin
			case (st)
				MIC_APB_IDLE: begin
					if (first) begin
						st      <= MIC_APB_RESP;
						pready  <= 1'b1;
						pslverr <= !mapped;
						prdata  <= (mapped && !pwrite) ? rd_data : `MIC_RST_WORD;
					end
				end
				MIC_APB_RESP: begin
					st      <= MIC_APB_IDLE;
					pready  <= 1'b0;
					pslverr <= 1'b0;
				end
				default: st <= MIC_APB_IDLE;
			endcase
		end
	end

endmodule // mic_apb

// file: rtl/mic_arb.sv
// Interrupt priority choice, cause code and vector target
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_arb (
	// Enabled pending sources: 0 software, 1 timer, 2 external
	input  wire logic [2:0]  en_pend,
	input  wire logic        gie,
	// Vector register
	input  wire logic [29:0] base,
	input  wire logic        vect,
	// Chosen interrupt
	output logic             take,
	output logic [9:0]       code,
	output logic [31:0]      irq_pc
);

	wire [31:0] base_pc;
	wire [31:0] offset;

	assign take = gie && (|en_pend); // RL1
	// External outranks software, software outranks timer
	assign code = en_pend[2] ? `MIC_CODE_EXT :                 // RL20 RL9
		en_pend[0] ? `MIC_CODE_SW : `MIC_CODE_TMR;            // RL13
	assign base_pc = {base, 2'b00};
	assign offset  = {20'h0_0000, code, 2'b00};
	assign irq_pc  = vect ? (base_pc + offset) : base_pc;   // RL7 RL5

endmodule // mic_arb

// file: rtl/mic_defs.svh
// Constants of the machine interrupt control registers
//
// Behaviour
// RL1: An interrupt is taken only with global enable bit 3 and its own enable set.
// RL2: Status bit 7 holds the previous global enable, readable and writable.
// RL3: Status bits 12:11 hold the previous privilege; other low bits are reserved.
// RL4: Vector mode in bits 1:0: 0 direct, 1 vectored, 2 and up reserved.
// RL5: Direct mode sends every exception and interrupt to the vector base.
// RL6: Handler software reads the cause register to identify the event.
// RL7: Vectored mode sends an interrupt to base plus four times its cause code.
// RL8: Software aligns a vectored base to 64 bytes; base sits in bits 31:2.
// RL9: All platform controller interrupts share cause code 11, one vector slot.
// RL10: Enable register has software, timer, external enables at bits 3, 7, 11.
// RL11: Pending register shows read-only flags at bits 3, 7, 11.
// RL12: An interrupt trap sets cause bit 31 to one.
// RL13: Interrupt cause code is the pending bit position: 3, 7 or 11.
// RL14: A synchronous exception trap clears cause bit 31.
// RL15: Cause holds the code in bits 9:0, flag in 31; 30:10 reserved.
// RL16: Exception codes 0 to 8 and 11 are valid; others are reserved.
// RL17: Entry copies global enable to previous enable, clears it, saves privilege.
// RL18: Entry saves the current program counter into the return address register.
// RL19: Return restores privilege, global enable and resumes at the saved address.
// RL20: Simultaneous interrupts are taken external first, then software, then timer.
// RL21: Vectored mode still sends synchronous exceptions to the plain base.
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// Register byte offsets
`define MIC_OFF_STATUS 12'h000
`define MIC_OFF_TVEC   12'h004
`define MIC_OFF_IE     12'h008
`define MIC_OFF_IP     12'h00C
`define MIC_OFF_CAUSE  12'h010
`define MIC_OFF_EPC    12'h014

// Field positions
`define MIC_GIE_BIT    3
`define MIC_PIE_BIT    7
`define MIC_PPL_LO     11
`define MIC_PPL_HI     12
`define MIC_SW_BIT     3
`define MIC_TMR_BIT    7
`define MIC_EXT_BIT    11
`define MIC_IRQ_FLAG   31

// Vector modes and privilege levels
`define MIC_MODE_DIRECT 2'h0
`define MIC_MODE_VECT   2'h1
`define MIC_PRIV_U      2'h0
`define MIC_PRIV_M      2'h3

// Interrupt cause codes
`define MIC_CODE_SW    10'h003
`define MIC_CODE_TMR   10'h007
`define MIC_CODE_EXT   10'h00B

// Synchronous exception codes
`define MIC_EXC_ILLEGAL 10'h002
`define MIC_EXC_LASTLO  10'h008
`define MIC_EXC_ECALL_M 10'h00B

// Reset values
`define MIC_RST_WORD   32'h0000_0000
`define MIC_RST_CODE   10'h000

`endif

// file: rtl/mic_pkg.sv
// Types shared by the machine interrupt control register block
package mic_pkg;

	typedef enum logic [0:0] {
		MIC_APB_IDLE,
		MIC_APB_RESP
	} mic_apb_st_t;

	// Synchronous exception report from the pipeline
	typedef struct packed {
		logic        valid;
		logic [9:0]  code;
	} mic_exc_t;

	// Program counter redirect toward the pipeline
	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
	} mic_redir_t;

endpackage

// file: rtl/mic_top.sv
// Machine mode trap and interrupt control registers with APB access
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_top
	import mic_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Pipeline
	input  mic_exc_t         exc,
	input  wire logic [31:0] cur_pc,
	input  wire logic        trap_return_instruction,
	output mic_redir_t       redir,
	output logic [1:0]       priv_mode,
	// Interrupt sources, levels
	input  wire logic        sw_irq,
	input  wire logic        timer_irq,
	input  wire logic        ext_irq
);

	// Architectural state
	logic        gie;
	logic        prior_irq_enable;
	logic [1:0]  prior_privilege;
	logic [29:0] tvec_base;
	logic        tvec_vect;
	logic [2:0]  irq_en;
	logic [2:0]  irq_pend;
	logic        cause_irq;
	logic [9:0]  cause_code;
	logic [31:0] epc;

	// Decode
	wire hit_status;
	wire hit_tvec;
	wire hit_ie;
	wire hit_ip;
	wire hit_cause;
	wire hit_epc;
	wire mapped;
	wire wr_stb;
	wire wr_status;
	wire wr_tvec;
	wire wr_ie;
	wire wr_cause;
	wire wr_epc;

	assign hit_status = (paddr == `MIC_OFF_STATUS);
	assign hit_tvec   = (paddr == `MIC_OFF_TVEC);
	assign hit_ie     = (paddr == `MIC_OFF_IE);
	assign hit_ip     = (paddr == `MIC_OFF_IP);
	assign hit_cause  = (paddr == `MIC_OFF_CAUSE);
	assign hit_epc    = (paddr == `MIC_OFF_EPC);
	// Pending is read only, so a write to it is refused with an error
	assign mapped = hit_status || hit_tvec || hit_ie || hit_cause || hit_epc ||
		(hit_ip && !pwrite);                                  // RL11
	assign wr_status = wr_stb && hit_status;
	assign wr_tvec   = wr_stb && hit_tvec;
	assign wr_ie     = wr_stb && hit_ie;
	assign wr_cause  = wr_stb && hit_cause;
	assign wr_epc    = wr_stb && hit_epc;

	// Read views; reserved bits read as zero
	wire [31:0] status_view;
	wire [31:0] tvec_view;
	wire [31:0] ie_view;
	wire [31:0] ip_view;
	wire [31:0] cause_view;
	wire [31:0] rd_data;

	assign status_view = {19'h0_0000, prior_privilege, 3'h0,  // RL3
		prior_irq_enable, 3'h0, gie, 3'h0};                   // RL2
	assign tvec_view = {tvec_base, 1'b0, tvec_vect};         // RL4
	assign ie_view = {20'h0_0000, irq_en[2], 3'h0, irq_en[1], // RL10
		3'h0, irq_en[0], 3'h0};
	assign ip_view = {20'h0_0000, irq_pend[2], 3'h0,          // RL11
		irq_pend[1], 3'h0, irq_pend[0], 3'h0};
	assign cause_view = {cause_irq, 21'h00_0000, cause_code}; // RL15
	assign rd_data = hit_status ? status_view :
		hit_tvec ? tvec_view :
		hit_ie ? ie_view :
		hit_ip ? ip_view :
		hit_cause ? cause_view :
		hit_epc ? epc : `MIC_RST_WORD;

	mic_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.mapped  (mapped),
		.rd_data (rd_data),
		.wr_stb  (wr_stb)
	);

	// Pending flags follow the source levels, one per source
	wire [2:0] src;
	assign src = {ext_irq, timer_irq, sw_irq};

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_pend
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					irq_pend[i] <= 1'b0;
				end else if (ce) begin
					irq_pend[i] <= src[i]; // RL11
				end
			end
		end
	endgenerate

	// Trap selection: exception, then return, then interrupt
	wire [2:0]  en_pend;
	wire        arb_take;
	wire [9:0]  irq_code;
	wire [31:0] irq_pc;
	wire        take_exc;
	wire        take_ret;
	wire        take_irq;
	wire        trap;
	wire [9:0]  exc_code;

	assign en_pend = irq_en & irq_pend; // RL1

	mic_arb u_arb (
		.en_pend (en_pend),
		.gie     (gie),
		.base    (tvec_base),
		.vect    (tvec_vect),
		.take    (arb_take),
		.code    (irq_code),
		.irq_pc  (irq_pc)
	);

	assign take_exc = exc.valid;
	assign take_ret = !take_exc && trap_return_instruction;
	assign take_irq = !take_exc && !take_ret && arb_take;
	assign trap     = take_exc || take_irq;
	// A reserved code from the pipeline is recorded as an illegal instruction
	assign exc_code = ((exc.code <= `MIC_EXC_LASTLO) ||   // RL16
		(exc.code == `MIC_EXC_ECALL_M)) ? exc.code : `MIC_EXC_ILLEGAL;

	// Next values; hardware trap updates win over a same-cycle software write
	wire        next_gie;
	wire        next_pie;
	wire [1:0]  next_ppl;
	wire [1:0]  next_priv;
	wire [31:0] next_epc;
	wire        next_cause_irq;
	wire [9:0]  next_cause_code;
	wire        next_vect;
	wire [31:0] next_pc;
	wire        legal_mode;

	assign next_gie = trap ? 1'b0 :                           // RL17
		take_ret ? prior_irq_enable :                         // RL19
		wr_status ? pwdata[`MIC_GIE_BIT] : gie;
	assign next_pie = trap ? gie :                            // RL17
		take_ret ? 1'b1 :
		wr_status ? pwdata[`MIC_PIE_BIT] : prior_irq_enable;  // RL2
	assign next_ppl = trap ? priv_mode :                      // RL17
		take_ret ? `MIC_PRIV_U :
		wr_status ? pwdata[`MIC_PPL_HI:`MIC_PPL_LO] : prior_privilege; // RL3
	assign next_priv = trap ? `MIC_PRIV_M :
		take_ret ? prior_privilege : priv_mode;               // RL19
	assign next_epc = trap ? cur_pc :                         // RL18
		wr_epc ? pwdata : epc;
	assign next_cause_irq = take_irq ? 1'b1 :                 // RL12
		take_exc ? 1'b0 :                                     // RL14
		wr_cause ? pwdata[`MIC_IRQ_FLAG] : cause_irq;
	assign next_cause_code = take_irq ? irq_code :            // RL13
		take_exc ? exc_code :
		wr_cause ? pwdata[9:0] : cause_code;                  // RL15
	// A reserved mode write leaves the mode unchanged
	assign legal_mode = (pwdata[1:0] == `MIC_MODE_DIRECT) ||  // RL4
		(pwdata[1:0] == `MIC_MODE_VECT);
	assign next_vect = (wr_tvec && legal_mode) ? pwdata[0] : tvec_vect;
	assign next_pc = take_irq ? irq_pc :                      // RL7
		take_ret ? epc : {tvec_base, 2'b00};                  // RL5 RL21

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie              <= 1'b0;
			prior_irq_enable <= 1'b0;
			prior_privilege  <= `MIC_PRIV_U;
			priv_mode        <= `MIC_PRIV_M;
			epc              <= `MIC_RST_WORD;
			cause_irq        <= 1'b0;
			cause_code       <= `MIC_RST_CODE;
		end else if (ce) begin
			gie              <= next_gie;
			prior_irq_enable <= next_pie;
			prior_privilege  <= next_ppl;
			priv_mode        <= next_priv;
			epc              <= next_epc;
			cause_irq        <= next_cause_irq;
			cause_code       <= next_cause_code;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tvec_base <= 30'h0000_0000;
			tvec_vect <= 1'b0;
			irq_en    <= 3'h0;
		end else if (ce) begin
			tvec_vect <= next_vect;
			if (wr_tvec) begin
				tvec_base <= pwdata[31:2];
			end
			if (wr_ie) begin
				irq_en <= {pwdata[`MIC_EXT_BIT], pwdata[`MIC_TMR_BIT], // RL10
					pwdata[`MIC_SW_BIT]};
			end
		end
	end

	// Redirect is a one-cycle pulse; the target is held until the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			redir <= '0;
		end else if (ce) begin
			redir.valid <= trap || take_ret;
			if (trap || take_ret) begin
				redir.pc <= next_pc;
			end
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_irq_gated: assert property ( // RL1
		(ce && take_irq) |-> (gie && (|(irq_en & irq_pend))))
		else $error("interrupt taken while not enabled");
	chk_entry_enable: assert property ( // RL17
		(ce && trap) |=> (!gie && (prior_irq_enable == $past(gie))))
		else $error("entry did not save and clear global enable");
	chk_entry_priv: assert property ( // RL3
		(ce && trap) |=> ((prior_privilege == $past(priv_mode)) &&
		(priv_mode == `MIC_PRIV_M)))
		else $error("entry did not record prior privilege");
	chk_direct_target: assert property ( // RL5
		(ce && trap && (take_exc || !tvec_vect)) |=>
		(redir.valid && (redir.pc == {$past(tvec_base), 2'b00})))
		else $error("direct or exception target is not the base");
	chk_vector_target: assert property ( // RL7
		(ce && take_irq && tvec_vect) |=> (redir.valid &&
		(redir.pc == ({$past(tvec_base), 2'b00} + {20'h0_0000, cause_code, 2'b00}))))
		else $error("vectored target is wrong");
	chk_ext_first: assert property ( // RL20
		(ce && take_irq && en_pend[2]) |=>
		(cause_irq && (cause_code == `MIC_CODE_EXT)))
		else $error("external interrupt not given code 11");
	chk_sw_over_tmr: assert property ( // RL20
		(ce && take_irq && !en_pend[2] && en_pend[0]) |=>
		(cause_code == `MIC_CODE_SW))
		else $error("software interrupt lost to timer");
	chk_exc_flag: assert property ( // RL14
		(ce && take_exc) |=> (!cause_irq && !redir.pc[1] && !redir.pc[0]))
		else $error("exception left the interrupt flag set");
	chk_epc_save: assert property ( // RL18
		(ce && trap) |=> (epc == $past(cur_pc)))
		else $error("return address not saved");
	chk_return_path: assert property ( // RL19
		(ce && take_ret) |=> (redir.valid && (redir.pc == $past(epc)) &&
		(gie == $past(prior_irq_enable)) && (priv_mode == $past(prior_privilege))))
		else $error("return did not restore state");
	chk_no_stray_redir: assert property ( // RL1
		(ce && !exc.valid && !trap_return_instruction && !(gie && (|(irq_en & irq_pend))))
		|=> !redir.valid)
		else $error("redirect without a request");
	chk_irq_cause: assert property ( // RL12 RL13
		(ce && take_irq) |=> (cause_irq && ((cause_code == `MIC_CODE_SW) ||
		(cause_code == `MIC_CODE_TMR) || (cause_code == `MIC_CODE_EXT))))
		else $error("interrupt cause not flagged or not a valid code");
	chk_exc_code: assert property ( // RL16
		(ce && take_exc && (exc.code <= `MIC_EXC_LASTLO)) |=>
		(cause_code == $past(exc.code)))
		else $error("exception code not recorded");

	cov_direct_irq: cover property (ce && take_irq && !tvec_vect);
	cov_vector_irq: cover property (ce && take_irq && tvec_vect);
	cov_exception:  cover property (ce && take_exc);
	cov_return:     cover property (ce && take_ret);
	cov_frozen:     cover property (!ce && exc.valid);

endmodule // mic_top

// file: testbench/mic_hart_model.sv
// Pipeline and interrupt source model facing the trap control registers
`timescale 1ns/1ps
module mic_hart_model
	import mic_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Pipeline
	input  mic_redir_t       redir,
	output mic_exc_t         exc,
	output logic [31:0]      cur_pc,
	output logic             trap_return_instruction,
	// Source levels
	output logic             sw_irq,
	output logic             timer_irq,
	output logic             ext_irq
);
	initial begin
		exc = '0;
		cur_pc = 32'h0000_2000;
		trap_return_instruction = 1'b0;
		{ext_irq, timer_irq, sw_irq} = 3'h0;
	end

	// Fetch resumes where the block sends us, so saved pcs stay meaningful
	always @(posedge pclk) begin
		if (presetn && redir.valid === 1'b1) begin
			cur_pc <= redir.pc;
		end
	end

	// Requests stand one cycle only; a longer one would be taken twice
	task automatic req(input logic ret, input logic [9:0] code);
		@(posedge pclk);
		exc <= {~ret, code};
		trap_return_instruction <= ret;
		@(posedge pclk);
		exc <= '0;
		trap_return_instruction <= 1'b0;
	endtask

	task automatic set_src(input logic [2:0] v);
		@(posedge pclk);
		{ext_irq, timer_irq, sw_irq} <= v;
	endtask
endmodule // mic_hart_model

// file: testbench/tb_top.sv
// Self-checking bench for the machine trap control registers
`timescale 1ns/1ps
`include "mic_defs.svh"
module tb_top
	import mic_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] cur_pc;
	logic [1:0]  priv_mode;
	logic        trap_return_instruction;
	logic        sw_irq;
	logic        timer_irq;
	logic        ext_irq;
	mic_exc_t    exc;
	mic_redir_t  redir;
	logic [31:0] rd;
	logic        err;
	logic [31:0] pc0;
	int          fail_count;
	int          checks;
	int          cycles;
	int          redirs;
	int          r0;
	int          n;
	logic [2:0]  srcs [5] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h3};
	int          codes [5] = '{3, 7, 11, 11, 3};

	mic_top i_mic_top (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exc(exc), .cur_pc(cur_pc),
		.trap_return_instruction(trap_return_instruction), .redir(redir),
		.priv_mode(priv_mode), .sw_irq(sw_irq), .timer_irq(timer_irq), .ext_irq(ext_irq)
	);

	mic_hart_model i_mic_hart_model (
		.pclk(pclk), .presetn(presetn), .redir(redir), .exc(exc), .cur_pc(cur_pc),
		.trap_return_instruction(trap_return_instruction), .sw_irq(sw_irq),
		.timer_irq(timer_irq), .ext_irq(ext_irq)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (redir.valid === 1'b1) redirs++;
		if (cycles == 5000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// Edges counted until the redirect pulse is seen
	task automatic wait_redir(input int exp_n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (redir.valid !== 1'b1);
		chk(32'(n), 32'(exp_n));
	endtask

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		fail_count = 0;
		checks = 0;
		cycles = 0;
		redirs = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk(32'(priv_mode), 32'h0000_0003);
		for (int a = 0; a < 24; a += 4) rdchk(12'(a), 32'h0000_0000);
		rdchk(12'h018, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		apb(1'b1, `MIC_OFF_IP, 32'hFFFF_FFFF);
		chk(32'(err), 32'h0000_0001);
		$display("test reset_and_refusals done");
		apb(1'b1, `MIC_OFF_STATUS, 32'hFFFF_FFFF);
		rdchk(`MIC_OFF_STATUS, 32'h0000_1888);
		apb(1'b1, `MIC_OFF_IE, 32'hFFFF_FFFF);
		rdchk(`MIC_OFF_IE, 32'h0000_0888);
		apb(1'b1, `MIC_OFF_CAUSE, 32'hFFFF_FFFF);
		rdchk(`MIC_OFF_CAUSE, 32'h8000_03FF);
		apb(1'b1, `MIC_OFF_TVEC, 32'hFFFF_FFFF);
		rdchk(`MIC_OFF_TVEC, 32'hFFFF_FFFC);
		apb(1'b1, `MIC_OFF_TVEC, 32'hFFFF_FFFD);
		rdchk(`MIC_OFF_TVEC, 32'hFFFF_FFFD);
		$display("test field_masks done");
		apb(1'b1, `MIC_OFF_STATUS, 32'h0000_0000);
		i_mic_hart_model.set_src(3'h7);
		r0 = redirs;
		rdchk(`MIC_OFF_IP, 32'h0000_0888);
		apb(1'b1, `MIC_OFF_IE, 32'h0000_0000);
		apb(1'b1, `MIC_OFF_STATUS, 32'h0000_0008);
		chk(32'(redirs), 32'(r0));
		i_mic_hart_model.set_src(3'h0);
		$display("test gating done");
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 5; k++) begin
				apb(1'b1, `MIC_OFF_TVEC, 32'h0000_0400 | 32'(m));
				apb(1'b1, `MIC_OFF_IE, 32'h0000_0888);
				apb(1'b1, `MIC_OFF_STATUS, 32'h0000_0008);
				pc0 = cur_pc;
				i_mic_hart_model.set_src(srcs[k]);
				wait_redir(3);
				chk(redir.pc, 32'h0000_0400 + 32'(m * 4 * codes[k]));
				i_mic_hart_model.set_src(3'h0);
				rdchk(`MIC_OFF_CAUSE, 32'h8000_0000 | 32'(codes[k]));
				rdchk(`MIC_OFF_EPC, pc0);
				rdchk(`MIC_OFF_STATUS, 32'h0000_1880);
				i_mic_hart_model.req(1'b1, 10'h000);
				wait_redir(1);
				chk(redir.pc, pc0);
				chk(32'(priv_mode), 32'h0000_0003);
				rdchk(`MIC_OFF_STATUS, 32'h0000_0088);
			end
		end
		$display("test interrupts done");
		i_mic_hart_model.req(1'b1, 10'h000);
		wait_redir(1);
		chk(32'(priv_mode), 32'h0000_0000);
		i_mic_hart_model.set_src(3'h2);
		wait_redir(3);
		i_mic_hart_model.set_src(3'h0);
		rdchk(`MIC_OFF_STATUS, 32'h0000_0080);
		chk(32'(priv_mode), 32'h0000_0003);
		for (int c = 0; c < 13; c++) begin
			pc0 = cur_pc;
			i_mic_hart_model.req(1'b0, 10'(c));
			wait_redir(1);
			chk(redir.pc, 32'h0000_0400);
			rdchk(`MIC_OFF_CAUSE, (c == 9 || c == 10 || c > 11) ? 32'h2 : 32'(c));
			rdchk(`MIC_OFF_EPC, pc0);
		end
		$display("test exceptions done");
		// An exception offered while the enable is low must leave no trace
		@(posedge pclk);
		ce <= 1'b0;
		r0 = redirs;
		i_mic_hart_model.req(1'b0, 10'h003);
		repeat (2) @(posedge pclk);
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'(redirs), 32'(r0));
		rdchk(`MIC_OFF_CAUSE, 32'h0000_0002);
		$display("test clock_enable done");
		wrap_up();
	end
endmodule // tb_top
